// >>> shared/conv_pkg.sv
// Package for the converter control block: widths, timing counts, state codes, carriers.
// Assumes a 40 MHz system clock.
package conv_pkg;
    localparam int          RES_W         = 12;
    localparam int          CLK_MHZ       = 40;
    // Conversion must end within this time after the start edge
    localparam int          CONV_MAX_NS   = 750;
    localparam int          CONV_MAX_CYC  = (CONV_MAX_NS * CLK_MHZ) / 1000;
    // Internal bit clock: one trial per TRIAL_CYC cycles
    localparam int          TRIAL_CYC     = 2;
    // Nap wake-up time
    localparam int          NAP_WAKE_NS   = 200;
    localparam int          NAP_WAKE_CYC  = (NAP_WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [11:0] RESULT_RST    = 12'h000;
    localparam logic [3:0]  BIT_LAST      = 4'h0;
    localparam logic [3:0]  BIT_FIRST     = 4'hB;
    localparam logic [7:0]  WAKE_CNT      = 8'(NAP_WAKE_CYC);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CONV  = 4'b0010,
        ST_NAP   = 4'b0100,
        ST_SLEEP = 4'b1000
    } conv_state_t;

    // Word handed to the output buffer
    typedef struct packed {
        logic [RES_W-1:0] data;
    } result_word_t;

    // Pin group of the host port
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic convert_start_n;
        logic power_down_n;
        logic shutdown_kind_select;
    } host_pins_t;
endpackage

// >>> src/result_buffer.sv
// Two-entry buffer between the conversion engine and the result latches.
// Same clock on both sides; drain side may stall.
`timescale 1ns/10ps
module result_buffer
    import conv_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire result_word_t in_word,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output result_word_t      out_word
);
    typedef struct packed {
        result_word_t [1:0] mem;
        logic               wr_ptr;
        logic               rd_ptr;
        logic [1:0]         count;
    } buf_state_t;

    buf_state_t cur_ff;
    buf_state_t nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        if (in_valid && in_ready) begin
            nxt_ff.mem[cur_ff.wr_ptr] = in_word;
            nxt_ff.wr_ptr             = ~cur_ff.wr_ptr;
        end
        if (out_valid && out_ready) begin
            nxt_ff.rd_ptr = ~cur_ff.rd_ptr;
        end
        nxt_ff.count = cur_ff.count + 2'((in_valid && in_ready) ? 1 : 0)
                                    - 2'((out_valid && out_ready) ? 1 : 0);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign in_ready  = (cur_ff.count != 2'h2);
    assign out_valid = (cur_ff.count != 2'h0);
    assign out_word  = cur_ff.mem[cur_ff.rd_ptr];

    count_range_a: assert property (@(posedge clk) disable iff (!arst_n)
        cur_ff.count <= 2'h2) else $error("buffer count out of range");
endmodule

// >>> src/conv_control.sv
// Control logic of a 12-bit successive-approximation converter with parallel host port.
// Comparator decision arrives as a synchronous input; host pins are asynchronous.
//
// Operation
// - Kind select low sleep, high nap
// - Power-down low enters selected shutdown
// - Drive result only when read and select low
// - Start on falling edge of start strobe
// - Strobes ignored unless chip select low
// - Busy low during whole conversion
// - Result valid by busy rising edge
// - Clear approximation register at conversion start
// - Start edges ignored while converting
// - One bit per trial, MSB first
// - Copy final word into output latches
// - Result delivered as one parallel word
// - Conversion ends within 0.75 us
// - Result is two's complement difference
// - Nap wake-up delay before next start
`timescale 1ns/10ps
module conv_control
    import conv_pkg::*;
(
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             ARST_N,
    // Host control pins
    input  wire logic             CS_N,
    input  wire logic             RD_N,
    input  wire logic             CONVERT_START_N,
    input  wire logic             POWER_DOWN_N,
    input  wire logic             SHUTDOWN_KIND_SELECT,
    // Comparator decision: 1 keeps the trial bit
    input  wire logic             COMPARE_KEEP,
    // Status and data pins
    output logic                  BUSY,
    output logic [RES_W-1:0]      RESULT_BITS_O,
    output logic [RES_W-1:0]      RESULT_BITS_OE,
    // Power state to the analog section
    output logic                  NAP_ACTIVE,
    output logic                  SLEEP_ACTIVE,
    output logic                  WAKE_READY
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        host_pins_t         s1;
        host_pins_t         s2;
        host_pins_t         s3;
        host_pins_t         filt;
        logic               start_prev;
        conv_state_t        state;
        logic [RES_W-1:0]   approximation_register;
        logic [3:0]         bit_idx;
        logic [1:0]         trial_div;
        logic [7:0]         wake_cnt;
        logic               push;
        logic [RES_W-1:0]   latch;
        logic               busy;
    } ctl_state_t;

    ctl_state_t   cur_ff;
    ctl_state_t   nxt_ff;
    host_pins_t   pins_raw;
    host_pins_t   pins;
    logic         start_level;
    logic         start_edge;
    logic         final_trial;
    logic         buf_in_ready;
    logic         buf_out_valid;
    result_word_t buf_in_word;
    result_word_t buf_out_word;

    function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] idx);
        bit_mask = RES_W'(1) << idx;
    endfunction

    // Offset binary approximation to two's complement
    function automatic logic [RES_W-1:0] to_twos(input logic [RES_W-1:0] w);
        to_twos = {~w[RES_W-1], w[RES_W-2:0]};
    endfunction

    assign pins_raw = '{cs_n: CS_N, rd_n: RD_N, convert_start_n: CONVERT_START_N,
                        power_down_n: POWER_DOWN_N, shutdown_kind_select: SHUTDOWN_KIND_SELECT};

    // Filtered pins: a change counts once stages two and three agree
    always_comb begin
        pins = cur_ff.filt;
        if (cur_ff.s2 == cur_ff.s3) begin
            pins = cur_ff.s3;
        end
    end

    assign start_level = ~pins.convert_start_n & ~pins.cs_n;
    assign start_edge  = start_level & ~cur_ff.start_prev;
    // Last decision of the final trial goes straight into the word
    assign final_trial = (cur_ff.state == ST_CONV) && (cur_ff.trial_div == 2'(TRIAL_CYC - 1))
                         && (cur_ff.bit_idx == BIT_LAST);
    assign buf_in_word = '{data: to_twos({cur_ff.approximation_register[RES_W-1:1], COMPARE_KEEP})};

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        nxt_ff      = cur_ff;
        nxt_ff.s1   = pins_raw;
        nxt_ff.s2   = cur_ff.s1;
        nxt_ff.s3   = cur_ff.s2;
        nxt_ff.filt = pins;
        nxt_ff.start_prev = start_level;
        nxt_ff.push       = 1'b0;
        if (cur_ff.wake_cnt != 8'h00) begin
            nxt_ff.wake_cnt = cur_ff.wake_cnt - 8'h01;
        end
        unique case (cur_ff.state)
            ST_IDLE: begin
                nxt_ff.busy = 1'b1;
                if (!pins.power_down_n) begin
                    nxt_ff.state = pins.shutdown_kind_select ? ST_NAP : ST_SLEEP;
                // start accepted only when idle and awake
                end else if (start_edge && cur_ff.wake_cnt == 8'h00) begin
                    nxt_ff.state                  = ST_CONV;
                    nxt_ff.approximation_register = bit_mask(BIT_FIRST);
                    nxt_ff.bit_idx                = BIT_FIRST;
                    nxt_ff.trial_div              = 2'h0;
                    nxt_ff.busy                   = 1'b0;
                end
            end
            ST_CONV: begin
                nxt_ff.busy      = 1'b0;
                nxt_ff.trial_div = cur_ff.trial_div + 2'h1;
                // one decision per trial, MSB down
                if (cur_ff.trial_div == 2'(TRIAL_CYC - 1)) begin
                    nxt_ff.trial_div = 2'h0;
                    if (!COMPARE_KEEP) begin
                        nxt_ff.approximation_register[cur_ff.bit_idx] = 1'b0;
                    end
                    if (cur_ff.bit_idx == BIT_LAST) begin
                        nxt_ff.state = ST_IDLE;
                    end else begin
                        nxt_ff.bit_idx = cur_ff.bit_idx - 4'h1;
                        nxt_ff.approximation_register[cur_ff.bit_idx - 4'h1] = 1'b1;
                    end
                end
            end
            ST_NAP, ST_SLEEP: begin
                nxt_ff.busy = 1'b1;
                if (pins.power_down_n) begin
                    nxt_ff.state    = ST_IDLE;
                    nxt_ff.wake_cnt = (cur_ff.state == ST_NAP) ? WAKE_CNT : 8'h00;
                end
            end
            default: begin
                nxt_ff.state = ST_IDLE;
                nxt_ff.busy  = 1'b1;
            end
        endcase
        // final two's complement word to buffer and latches
        if (final_trial) begin
            nxt_ff.push = 1'b1;
        end
        // latch loaded one cycle before busy rises
        if (buf_out_valid) begin
            nxt_ff.latch = buf_out_word.data;
        end
        if (cur_ff.state == ST_CONV && nxt_ff.state == ST_IDLE) begin
            nxt_ff.busy = 1'b0;
        end
        if (cur_ff.state == ST_IDLE && !cur_ff.push && !buf_out_valid && nxt_ff.state == ST_IDLE) begin
            nxt_ff.busy = 1'b1;
        end else if (cur_ff.state == ST_IDLE && nxt_ff.state == ST_IDLE) begin
            nxt_ff.busy = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cur_ff            <= '0;
            cur_ff.s1         <= '1;
            cur_ff.s2         <= '1;
            cur_ff.s3         <= '1;
            cur_ff.filt       <= '1;
            cur_ff.state      <= ST_IDLE;
            cur_ff.busy       <= 1'b1;
            cur_ff.latch      <= RESULT_RST;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ==========================================================
    // Result buffer
    // ==========================================================
    result_buffer u_buf (
        .clk       (CLK),
        .arst_n    (ARST_N),
        .in_valid  (final_trial),
        .in_ready  (buf_in_ready),
        .in_word   (buf_in_word),
        .out_valid (buf_out_valid),
        .out_ready (1'b1),
        .out_word  (buf_out_word)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign BUSY          = cur_ff.busy;
    assign RESULT_BITS_O = cur_ff.latch;
    assign RESULT_BITS_OE = (!pins.rd_n && !pins.cs_n) ? '1 : '0;
    assign NAP_ACTIVE    = (cur_ff.state == ST_NAP);
    assign SLEEP_ACTIVE  = (cur_ff.state == ST_SLEEP);
    assign WAKE_READY    = (cur_ff.wake_cnt == 8'h00) && (cur_ff.state == ST_IDLE);

    // ==========================================================
    // Checks
    // ==========================================================
    logic [7:0] low_cnt_ff;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            low_cnt_ff <= 8'h00;
        end else begin
            low_cnt_ff <= BUSY ? 8'h00 : low_cnt_ff + 8'h01;
        end
    end

    conv_time_limit_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        low_cnt_ff <= 8'(CONV_MAX_CYC)) else $error("conversion too long");
    start_clears_reg_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (cur_ff.state == ST_IDLE && nxt_ff.state == ST_CONV) |=> cur_ff.approximation_register == 12'h800)
        else $error("register not cleared at start");
    busy_in_conv_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        cur_ff.state == ST_CONV |-> !BUSY) else $error("busy high during conversion");
    no_restart_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        cur_ff.state == ST_CONV && cur_ff.bit_idx != BIT_FIRST |=> cur_ff.bit_idx != BIT_FIRST || cur_ff.state != ST_CONV)
        else $error("conversion restarted");
    drive_gate_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (RESULT_BITS_OE != 12'h000) |-> (!pins.rd_n && !pins.cs_n)) else $error("data driven without read");
    select_gate_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        pins.cs_n |-> !start_edge) else $error("start taken without select");
    edge_only_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        $past(start_level) |-> !start_edge) else $error("start on level");
    shutdown_kind_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (cur_ff.state == ST_IDLE && !pins.power_down_n) |=> (NAP_ACTIVE == $past(pins.shutdown_kind_select)))
        else $error("wrong shutdown mode");
    down_no_conv_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        (NAP_ACTIVE || SLEEP_ACTIVE) |-> BUSY) else $error("busy low in shutdown");
    data_at_busy_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        $rose(BUSY) && $past(cur_ff.state) != ST_NAP |-> RESULT_BITS_O == $past(RESULT_BITS_O))
        else $error("data changed at busy rise");
    nap_wake_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        $fell(NAP_ACTIVE) |-> !WAKE_READY [*8]) else $error("nap wake too short");
    buf_room_a: assert property (@(posedge CLK) disable iff (!ARST_N)
        final_trial |-> buf_in_ready) else $error("result word lost");

    conv_cov_c:  cover property (@(posedge CLK) disable iff (!ARST_N) $rose(BUSY));
    nap_cov_c:   cover property (@(posedge CLK) disable iff (!ARST_N) $fell(NAP_ACTIVE));
    sleep_cov_c: cover property (@(posedge CLK) disable iff (!ARST_N) SLEEP_ACTIVE);
endmodule

// >>> bench/host_bus_model.sv
// Host-side model: drives the parallel port pins and reads the three-state result bus.
// Assumes every task is called just after a falling clock edge.
`timescale 1ns/10ps
module host_bus_model
    import conv_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Device side
    input  wire logic             busy,
    input  wire logic [RES_W-1:0] data_bus,
    // Host pins
    output host_pins_t            pins
);
    localparam int ACQ_CYC  = 4;
    localparam int WAKE_GAP = NAP_WAKE_CYC + 4;

    int idle_cyc = 0;
    int wake_cyc = 0;

    initial begin
        pins = 5'h1F;
    end

    // ==========================================
    // Gap tracking
    always @(posedge clk) begin
        idle_cyc <= busy ? idle_cyc + 1 : 0;
        wake_cyc <= pins.power_down_n ? wake_cyc + 1 : 0;
    end

    // ==========================================
    // Pin tasks
    task automatic drive(input logic cs_n, input logic start_n, input logic rd_n);
        pins.cs_n            = cs_n;
        pins.convert_start_n = start_n;
        pins.rd_n            = rd_n;
    endtask

    task automatic start_edge(input logic sel_n, input logic wait_gap);
        while (wait_gap && (idle_cyc < ACQ_CYC || wake_cyc < WAKE_GAP)) begin
            @(negedge clk);
        end
        pins.cs_n = sel_n;
        @(negedge clk);
        pins.convert_start_n = 1'b0;
        repeat (4) @(negedge clk);
        pins.convert_start_n = 1'b1;
        pins.cs_n            = 1'b1;
        @(negedge clk);
    endtask

    task automatic read_word(input logic sel_n, output logic [RES_W-1:0] w);
        pins.cs_n = sel_n;
        pins.rd_n = 1'b0;
        repeat (5) @(negedge clk);
        w         = data_bus;
        pins.rd_n = 1'b1;
        pins.cs_n = 1'b1;
        @(negedge clk);
    endtask

    task automatic set_power(input logic kind, input logic pd_n);
        // Kind select settles before power-down moves
        pins.shutdown_kind_select = kind;
        @(negedge clk);
        pins.power_down_n = pd_n;
        @(negedge clk);
    endtask
endmodule

// >>> bench/sar_adc_conversion_control_tb.sv
// Self-checking bench for the converter control block.
// Assumes the host model drives all port pins; comparator decision is held per conversion.
`timescale 1ns/10ps
module sar_adc_conversion_control_tb
    import conv_pkg::*;
();
    logic             clk = 1'b0;
    logic             arst_n = 1'b0;
    logic             keep = 1'b0;
    host_pins_t       pins;
    logic             busy, nap_act, sleep_act, wake_rdy;
    logic [RES_W-1:0] res_o, res_oe, cap_word;
    wire  [RES_W-1:0] data_bus;
    logic             prev_busy = 1'b1;
    int               compares = 0, miscompares = 0, conv_count = 0;
    int               low_run = 0, last_run = 0, cycles = 0;

    always #12.5 clk = ~clk;

    for (genvar i = 0; i < RES_W; i++) begin : g_bus
        assign data_bus[i] = res_oe[i] ? res_o[i] : 1'bz;
    end

    conv_control u_dut (
        .CLK(clk), .ARST_N(arst_n), .CS_N(pins.cs_n), .RD_N(pins.rd_n),
        .CONVERT_START_N(pins.convert_start_n), .POWER_DOWN_N(pins.power_down_n),
        .SHUTDOWN_KIND_SELECT(pins.shutdown_kind_select), .COMPARE_KEEP(keep),
        .BUSY(busy), .RESULT_BITS_O(res_o), .RESULT_BITS_OE(res_oe),
        .NAP_ACTIVE(nap_act), .SLEEP_ACTIVE(sleep_act), .WAKE_READY(wake_rdy)
    );

    host_bus_model u_host (.clk(clk), .busy(busy), .data_bus(data_bus), .pins(pins));

    // ==========================================
    // Busy monitor and timeout
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (busy === 1'b0) low_run <= low_run + 1;
        if (busy === 1'b1 && prev_busy === 1'b0) begin
            cap_word   <= res_o;
            last_run   <= low_run;
            conv_count <= conv_count + 1;
            low_run    <= 0;
        end
        prev_busy <= busy;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ==========================================
    // Helpers
    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [RES_W-1:0] exp, input logic [RES_W-1:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_done(input int n);
        int t;
        t = 0;
        while (conv_count < n && t < 80) begin
            @(negedge clk);
            t++;
        end
    endtask

    task automatic check_run;
        check("busy low run", 12'h001, {11'h000, last_run >= RES_W * TRIAL_CYC && last_run <= CONV_MAX_CYC});
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        check("busy after reset", 12'h001, {11'h000, busy});
        check("enable after reset", 12'h000, res_oe);
        check("shutdown flags", 12'h000, {10'h000, nap_act, sleep_act});
    endtask

    task automatic t_convert(input logic k, input logic [RES_W-1:0] exp);
        int               n;
        logic [RES_W-1:0] w;
        n    = conv_count;
        keep = k;
        u_host.start_edge(1'b0, 1'b1);
        wait_done(n + 1);
        check("conversions", 12'(n + 1), 12'(conv_count));
        check_run();
        check("word at busy rise", exp, cap_word);
        check("idle enable", 12'h000, res_oe);
        u_host.read_word(1'b0, w);
        check("read word", exp, w);
    endtask

    task automatic t_level_hold;
        int n;
        n    = conv_count;
        keep = 1'b1;
        u_host.drive(1'b0, 1'b0, 1'b1);
        wait_done(n + 1);
        repeat (40) @(negedge clk);
        check("held low starts", 12'(n + 1), 12'(conv_count));
        u_host.drive(1'b1, 1'b1, 1'b1);
        @(negedge clk);
    endtask

    task automatic t_deselect;
        int               n;
        logic [RES_W-1:0] w;
        n = conv_count;
        u_host.start_edge(1'b1, 1'b1);
        repeat (40) @(negedge clk);
        check("deselected start", 12'(n), 12'(conv_count));
        u_host.read_word(1'b1, w);
        check("deselected bus", 12'hZZZ, w);
    endtask

    task automatic t_restart;
        int n;
        n    = conv_count;
        keep = 1'b0;
        u_host.start_edge(1'b0, 1'b1);
        u_host.start_edge(1'b0, 1'b0);
        wait_done(n + 1);
        repeat (40) @(negedge clk);
        check("restart ignored", 12'(n + 1), 12'(conv_count));
        check_run();
    endtask

    task automatic t_power;
        int n;
        int t;
        n = conv_count;
        u_host.set_power(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        check("nap flags", 12'h002, {10'h000, nap_act, sleep_act});
        u_host.start_edge(1'b0, 1'b0);
        repeat (10) @(negedge clk);
        check("start in nap", 12'(n), 12'(conv_count));
        check("busy in nap", 12'h001, {11'h000, busy});
        u_host.set_power(1'b1, 1'b1);
        u_host.start_edge(1'b0, 1'b0);
        repeat (10) @(negedge clk);
        check("start in wake", 12'(n), 12'(conv_count));
        t = 0;
        while (wake_rdy !== 1'b1 && t < 50) begin
            @(negedge clk);
            t++;
        end
        check("nap wake", 12'h001, {11'h000, wake_rdy});
        u_host.start_edge(1'b0, 1'b1);
        wait_done(n + 1);
        check("start after wake", 12'(n + 1), 12'(conv_count));
        u_host.set_power(1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check("sleep flags", 12'h001, {10'h000, nap_act, sleep_act});
        u_host.set_power(1'b0, 1'b1);
        repeat (60) @(negedge clk);
        check("sleep exit flags", 12'h000, {10'h000, nap_act, sleep_act});
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_convert(1'b1, 12'h7FF);
        t_convert(1'b0, 12'h800);
        t_level_hold();
        t_deselect();
        t_restart();
        t_power();
        print_verdict();
    end
endmodule
